// [sfpc_buf.sv]
/*
 * Two-entry buffer, head always in slot zero so the read side is a flop.
 * Assumes the writer offers only while wready is high.
 */
module sfpc_buf #(
    parameter int W = 9
) (
    input wire logic i_clk,
    input wire logic i_srst,
    sfpc_buf_if.store bus
);
    typedef struct packed {
        logic [W-1:0] head;
        logic [W-1:0] tail;
        logic [1:0] cnt;
        logic vld;
    } sfpc_bst_t;

    sfpc_bst_t q;
    sfpc_bst_t next_q;

    ////////////////////////////////////////////////////////////////////////
    // Pop shifts tail into head; push lands behind whatever remains
    always_comb begin
        next_q = q;
        if (bus.rready && q.cnt != sfpc_pkg::BUF_EMPTY) begin
            next_q.head = q.tail;
            next_q.cnt = q.cnt - 2'h1;
        end
        if (bus.wvalid && q.cnt != sfpc_pkg::BUF_FULL) begin
            if (next_q.cnt == sfpc_pkg::BUF_EMPTY) begin
                next_q.head = bus.wdata;
            end else begin
                next_q.tail = bus.wdata;
            end
            next_q.cnt = next_q.cnt + 2'h1;
        end
        // Valid kept in a flop so the block's output comes from a register
        next_q.vld = (next_q.cnt != sfpc_pkg::BUF_EMPTY);
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign bus.rdata = q.head;
    assign bus.rvalid = q.vld;
    // Ready from the count flop only, no path from the reader
    assign bus.wready = (q.cnt != sfpc_pkg::BUF_FULL);

    property p_buf_bound;
        @(posedge i_clk) disable iff (i_srst)
        q.cnt != 2'h3;
    endproperty
    a_buf_bound: assert property (p_buf_bound)
        else $error("buffer count past two");
endmodule

// [sfpc_buf_if.sv]
/*
 * Carrier between the pin control and its two-entry receive buffer.
 * Assumes both ends run on the same clock.
 */
interface sfpc_buf_if #(parameter int W = 9);
    logic [W-1:0] wdata;
    logic wvalid;
    logic wready;
    logic [W-1:0] rdata;
    logic rvalid;
    logic rready;
    modport wr (output wdata, output wvalid, input wready);
    modport store (input wdata, input wvalid, output wready,
                   output rdata, output rvalid, input rready);
endinterface

// [sfpc_host.sv]
/*
 * Host side model: drives select, serial clock and data in, reads data out.
 * Assumes one bench thread calls its tasks, just after system clock edges.
 */
module sfpc_host (
    input wire logic i_clk,
    input wire logic i_so,
    input wire logic i_so_oe,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si
);
    timeunit 1ns;
    timeprecision 1ps;

    logic act = 1'b0;
    logic si_d = 1'b0;
    logic tog = 1'b0;
    logic so_last = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Released data line wanders every cycle, so no stale level is seen
    always @(posedge i_clk) begin
        tog <= ~tog;
    end
    assign o_si = act ? si_d : tog;

    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Wait n system clocks, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // Select fall opens a frame, select rise closes it
    task automatic sel();
        o_cs_n = 1'b0;
        act = 1'b1;
        tick(8);
    endtask

    task automatic desel();
        o_cs_n = 1'b1;
        act = 1'b0;
        tick(8);
    endtask

    // Mode 3: data set on fall, device takes it on rise, MSB first.
    // Half periods of 8 clocks leave room for the pin filter latency.
    task automatic xbyte(input logic [7:0] tx, input int nb,
                         output logic [7:0] rx);
        for (int i = 7; i > 7 - nb; i--) begin
            o_sck = 1'b0;
            si_d = tx[i];
            tick(8);
            rx[i] = (i_so_oe === 1'b1) ? i_so : ~so_last;
            so_last = rx[i];
            o_sck = 1'b1;
            tick(8);
        end
    endtask

    // Clock toggling while deselected, data line wandering too
    task automatic noise();
        repeat (16) begin
            o_sck = ~o_sck;
            tick(8);
        end
    endtask
endmodule

// [sfpc_pkg.sv]
/*
 * Shared constants and types of the serial flash pin control block.
 * Assumes a single 25 MHz system clock; all pins arrive asynchronously.
 */
package sfpc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_NS = 40;
    localparam int POR_NS = 1000;
    // Least time, rounded up to whole cycles
    localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;
    localparam int POR_W = 5;
    localparam logic [POR_W-1:0] POR_DONE = POR_W'(POR_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Pin vector layout
    localparam int NPIN = 5;
    localparam int P_CS = 0;
    localparam int P_SCK = 1;
    localparam int P_SI = 2;
    localparam int P_WP = 3;
    localparam int P_RST = 4;
    // Idle levels: select high, clock low, data low, protect high, reset high
    localparam logic [NPIN-1:0] PIN_IDLE = 5'h19;

    ////////////////////////////////////////////////////////////////////////
    // Serial framing
    localparam int BYTE_W = 8;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [BYTE_W-1:0] TX_FILL = 8'hFF;
    localparam int RX_W = BYTE_W + 1;
    localparam logic [1:0] BUF_EMPTY = 2'h0;
    localparam logic [1:0] BUF_FULL = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_SEL, ST_BUSY, ST_RST} sfpc_state_t;

endpackage

// [sfpc_top.sv]
/*
 * Pin-level control of a serial flash host port: select framing, input
 * sampling on rising clock, output on falling clock, write protect and
 * reset pin handling, internal power-on reset.
 * Assumes opcode decoding and the self-timed array engine sit outside and
 * talk through the i_pe_* and o_pe_* ports.
 */
module sfpc_top (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_wp_n,
    input wire logic i_reset_n,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    output logic o_so,
    output logic o_so_oe,
    output logic [7:0] o_rx_data,
    output logic o_rx_opcode,
    output logic o_rx_valid,
    input wire logic i_rx_ready,
    output logic o_rx_overrun,
    input wire logic i_pe_cmd,
    input wire logic i_pe_done,
    output logic o_pe_start,
    output logic o_pe_rejected,
    output logic o_spr_write_ok,
    output logic o_standby,
    output logic o_busy,
    output logic o_in_reset,
    output logic o_abort
);
    typedef struct packed {
        logic [sfpc_pkg::NPIN-1:0] s1;
        logic [sfpc_pkg::NPIN-1:0] s2;
        logic [sfpc_pkg::NPIN-1:0] s3;
        logic [sfpc_pkg::NPIN-1:0] f;
        sfpc_pkg::sfpc_state_t st;
        logic [sfpc_pkg::POR_W-1:0] por;
        logic [2:0] rbit;
        logic [7:0] rsh;
        logic first;
        logic [2:0] tbit;
        logic [7:0] tsh;
        logic so;
        logic so_oe;
        logic tx_ready;
        logic [sfpc_pkg::RX_W-1:0] wdata;
        logic wvalid;
        logic overrun;
        logic armed;
        logic pe_start;
        logic rejected;
        logic spr_ok;
        logic standby;
        logic busy;
        logic in_reset;
        logic abort;
    } sfpc_st_t;

    sfpc_st_t q;
    sfpc_st_t next_q;
    logic [sfpc_pkg::NPIN-1:0] pins;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic [7:0] tx_byte;

    sfpc_buf_if #(.W(sfpc_pkg::RX_W)) rxb ();

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer lets a slow reader fall up to two bytes behind without losing one
    sfpc_buf #(.W(sfpc_pkg::RX_W)) u_rxbuf (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .bus(rxb.store)
    );
    assign rxb.wdata = q.wdata;
    assign rxb.wvalid = q.wvalid;
    assign rxb.rready = i_rx_ready;

    assign pins = {i_reset_n, i_wp_n, i_si, i_sck, i_cs_n};

    ////////////////////////////////////////////////////////////////////////
    // Whole next state
    always_comb begin
        next_q = q;
        tx_byte = sfpc_pkg::TX_FILL;
        // Three-stage capture; a level counts once stages two and three agree
        next_q.s1 = pins;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        for (int i = 0; i < sfpc_pkg::NPIN; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                next_q.f[i] = q.s3[i];
            end
        end
        cs_fall = q.f[sfpc_pkg::P_CS] && !next_q.f[sfpc_pkg::P_CS];
        cs_rise = !q.f[sfpc_pkg::P_CS] && next_q.f[sfpc_pkg::P_CS];
        sck_rise = !q.f[sfpc_pkg::P_SCK] && next_q.f[sfpc_pkg::P_SCK];
        sck_fall = q.f[sfpc_pkg::P_SCK] && !next_q.f[sfpc_pkg::P_SCK];
        // One-cycle pulses drop by default
        next_q.tx_ready = 1'b0;
        next_q.wvalid = 1'b0;
        next_q.overrun = 1'b0;
        next_q.pe_start = 1'b0;
        next_q.rejected = 1'b0;
        next_q.abort = 1'b0;
        next_q.spr_ok = next_q.f[sfpc_pkg::P_WP];
        if (q.por != sfpc_pkg::POR_DONE) begin
            next_q.por = q.por + 5'h1;
        end
        if (q.por != sfpc_pkg::POR_DONE || !next_q.f[sfpc_pkg::P_RST]) begin
            // Abort only marks a real drop into reset, not power-on
            next_q.abort = (q.por == sfpc_pkg::POR_DONE) &&
                           (q.st != sfpc_pkg::ST_RST);
            next_q.st = sfpc_pkg::ST_RST;
            next_q.armed = 1'b0;
            next_q.so_oe = 1'b0;
        end else begin
            case (q.st)
                sfpc_pkg::ST_RST: begin
                    // Reset exits to idle at once; a frame then waits for a fresh select fall
                    next_q.st = sfpc_pkg::ST_IDLE;
                end
                sfpc_pkg::ST_IDLE: begin
                    if (cs_fall) begin
                        next_q.st = sfpc_pkg::ST_SEL;
                        next_q.rbit = sfpc_pkg::BIT_FIRST;
                        next_q.tbit = sfpc_pkg::BIT_FIRST;
                        next_q.first = 1'b1;
                        next_q.armed = 1'b0;
                        next_q.so_oe = 1'b1;
                    end
                end
                sfpc_pkg::ST_SEL: begin
                    if (cs_rise) begin
                        next_q.so_oe = 1'b0;
                        next_q.armed = 1'b0;
                        // Protect may have fallen after arming
                        if (q.armed && next_q.f[sfpc_pkg::P_WP]) begin
                            next_q.pe_start = 1'b1;
                            next_q.st = sfpc_pkg::ST_BUSY;
                        end else begin
                            next_q.st = sfpc_pkg::ST_IDLE;
                        end
                    end else begin
                        // Input bits shift in at the rising edge, MSB first
                        if (sck_rise) begin
                            next_q.rsh = {q.rsh[6:0],
                                next_q.f[sfpc_pkg::P_SI]};
                            next_q.rbit = q.rbit + 3'h1;
                            if (q.rbit == sfpc_pkg::BIT_LAST) begin
                                next_q.wdata = {q.first, next_q.rsh};
                                next_q.first = 1'b0;
                                // The host cannot be stalled; a full
                                // buffer drops the byte and says so
                                if (rxb.wready) begin
                                    next_q.wvalid = 1'b1;
                                end else begin
                                    next_q.overrun = 1'b1;
                                end
                            end
                        end
                        // Output bits change at the falling edge, MSB first
                        if (sck_fall) begin
                            if (q.tbit == sfpc_pkg::BIT_FIRST) begin
                                if (i_tx_valid) begin
                                    tx_byte = i_tx_data;
                                    next_q.tx_ready = 1'b1;
                                end
                                next_q.so = tx_byte[7];
                                next_q.tsh = {tx_byte[6:0], 1'b0};
                            end else begin
                                next_q.so = q.tsh[7];
                                next_q.tsh = {q.tsh[6:0], 1'b0};
                            end
                            next_q.tbit = q.tbit + 3'h1;
                        end
                        // Under protect the command is dropped outright
                        if (i_pe_cmd) begin
                            if (!next_q.f[sfpc_pkg::P_WP]) begin
                                next_q.rejected = 1'b1;
                            end else begin
                                next_q.armed = 1'b1;
                            end
                        end
                    end
                end
                sfpc_pkg::ST_BUSY: begin
                    // Select activity is not served until the array is done
                    if (i_pe_done) begin
                        next_q.st = sfpc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    next_q.st = sfpc_pkg::ST_IDLE;
                end
            endcase
        end
        // Status flags registered from the state being entered
        next_q.standby = (next_q.st == sfpc_pkg::ST_IDLE);
        next_q.busy = (next_q.st == sfpc_pkg::ST_BUSY);
        next_q.in_reset = (next_q.st == sfpc_pkg::ST_RST);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            q <= '0;
            q.s1 <= sfpc_pkg::PIN_IDLE;
            q.s2 <= sfpc_pkg::PIN_IDLE;
            q.s3 <= sfpc_pkg::PIN_IDLE;
            q.f <= sfpc_pkg::PIN_IDLE;
            q.so <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign o_tx_ready = q.tx_ready;
    assign o_so = q.so;
    assign o_so_oe = q.so_oe;
    assign o_rx_data = rxb.rdata[7:0];
    assign o_rx_opcode = rxb.rdata[8];
    assign o_rx_valid = rxb.rvalid;
    assign o_rx_overrun = q.overrun;
    assign o_pe_start = q.pe_start;
    assign o_pe_rejected = q.rejected;
    assign o_spr_write_ok = q.spr_ok;
    assign o_standby = q.standby;
    assign o_busy = q.busy;
    assign o_in_reset = q.in_reset;
    assign o_abort = q.abort;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_cs_open;
        $fell(q.f[sfpc_pkg::P_CS]);
    endsequence
    sequence s_sck_up;
        $rose(q.f[sfpc_pkg::P_SCK]);
    endsequence
    sequence s_sck_down;
        $fell(q.f[sfpc_pkg::P_SCK]);
    endsequence

    property p_frame;
        $rose(q.st == sfpc_pkg::ST_SEL) |-> s_cs_open;
    endproperty
    a_frame: assert property (p_frame)
        else $error("operation opened without select fall");

    property p_hiz;
        q.st != sfpc_pkg::ST_SEL |-> !q.so_oe;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("output driven while deselected");

    property p_si_ignored;
        q.st != sfpc_pkg::ST_SEL |=> !q.wvalid && !q.overrun;
    endproperty
    a_si_ignored: assert property (p_si_ignored)
        else $error("byte accepted while deselected");

    property p_busy_start;
        q.pe_start |-> q.busy && $past(q.armed) && q.f[sfpc_pkg::P_CS] &&
            q.f[sfpc_pkg::P_WP];
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("self-timed start not tied to select rise");

    property p_sample_rise;
        ($changed(q.rbit) && q.rbit != sfpc_pkg::BIT_FIRST) |-> s_sck_up;
    endproperty
    a_sample_rise: assert property (p_sample_rise)
        else $error("input sampled off the rising edge");

    property p_so_fall;
        $changed(q.so) |-> s_sck_down;
    endproperty
    a_so_fall: assert property (p_so_fall)
        else $error("output changed off the falling edge");

    property p_wp_drop;
        $rose(q.armed) |-> q.f[sfpc_pkg::P_WP] && !q.rejected;
    endproperty
    a_wp_drop: assert property (p_wp_drop)
        else $error("program armed under write protect");

    property p_wp_reject;
        q.rejected |-> !q.f[sfpc_pkg::P_WP] ##1 !q.pe_start;
    endproperty
    a_wp_reject: assert property (p_wp_reject)
        else $error("rejected command still started");

    property p_spr_lock;
        !q.f[sfpc_pkg::P_WP] && q.por == sfpc_pkg::POR_DONE |-> !q.spr_ok;
    endproperty
    a_spr_lock: assert property (p_spr_lock)
        else $error("protection register writable under protect");

    property p_rst_hold;
        !q.f[sfpc_pkg::P_RST] |-> q.in_reset && !q.so_oe && !q.armed;
    endproperty
    a_rst_hold: assert property (p_rst_hold)
        else $error("not held idle while reset pin low");

    property p_rst_leave;
        // Stage three high means the pin cannot drop at the next edge
        (q.in_reset && q.f[sfpc_pkg::P_RST] && q.s3[sfpc_pkg::P_RST] &&
            q.por == sfpc_pkg::POR_DONE) |=> q.standby;
    endproperty
    a_rst_leave: assert property (p_rst_leave)
        else $error("no resume after reset pin high");

    property p_por;
        q.por != sfpc_pkg::POR_DONE |=> q.in_reset;
    endproperty
    a_por: assert property (p_por)
        else $error("left power-on reset early");

    property p_opcode_once;
        q.wvalid |=> !q.first;
    endproperty
    a_opcode_once: assert property (p_opcode_once)
        else $error("second byte marked as opcode");
endmodule

// [testbench.sv]
/*
 * Self-checking bench of the serial flash pin control block.
 * Assumes the host model of sfpc_host.sv and a 25 MHz system clock.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic srst, wp_n, reset_n, tx_valid, rx_ready, pe_cmd, pe_done;
    logic cs_n, sck, si, so, so_oe, tx_ready, rx_opcode, rx_valid;
    logic rx_overrun, pe_start, pe_rejected, spr_write_ok, standby;
    logic busy, in_reset, abort;
    logic [7:0] tx_data, rx_data, r;
    logic [31:0] seed = 32'h0001_04E7;
    logic [7:0] txq[$];
    logic [8:0] rxq[$];
    int err_count = 0;
    int checks = 0;
    int n_ovr, n_start, n_rej, n_abort;

    sfpc_top dut_u (
        .i_clk(clk), .i_srst(srst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
        .i_wp_n(wp_n), .i_reset_n(reset_n), .i_tx_data(tx_data),
        .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_so(so),
        .o_so_oe(so_oe), .o_rx_data(rx_data), .o_rx_opcode(rx_opcode),
        .o_rx_valid(rx_valid), .i_rx_ready(rx_ready),
        .o_rx_overrun(rx_overrun), .i_pe_cmd(pe_cmd), .i_pe_done(pe_done),
        .o_pe_start(pe_start), .o_pe_rejected(pe_rejected),
        .o_spr_write_ok(spr_write_ok), .o_standby(standby), .o_busy(busy),
        .o_in_reset(in_reset), .o_abort(abort)
    );
    sfpc_host host_u (
        .i_clk(clk), .i_so(so), .i_so_oe(so_oe), .o_cs_n(cs_n),
        .o_sck(sck), .o_si(si)
    );

    initial begin
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Collect popped entries and count pulses
    always @(posedge clk) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            rxq.push_back({rx_opcode, rx_data});
        if (rx_overrun === 1'b1)
            n_ovr++;
        if (pe_start === 1'b1)
            n_start++;
        if (pe_rejected === 1'b1)
            n_rej++;
        if (abort === 1'b1)
            n_abort++;
    end

    // Offer the next send byte once the current one was taken
    always @(posedge clk) begin
        if (tx_ready === 1'b1) begin
            #1;
            void'(txq.pop_front());
            tx_show();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tx_show();
        tx_valid = txq.size() > 0;
        tx_data = tx_valid ? txq[0] : 8'h00;
    endtask

    function automatic logic [7:0] rnd();
        seed = {1'b0, seed[31:1]} ^
               (seed[0] ? 32'h8020_0003 : 32'h0000_0000);
        return seed[7:0];
    endfunction

    // Unsupplied send bytes go out as all ones
    function automatic logic [8:0] exp_so(int k, int ntx, logic [7:0] v);
        return {1'b0, (k < ntx) ? v : 8'hFF};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk9(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chkn(input int got, input int exp);
        checks++;
        if (got != exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Bounded wait for standby; running out ends the run
    task automatic wait_sb();
        int i;
        for (i = 0; i < 100 && standby !== 1'b1; i++)
            tick(1);
        if (i == 100) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, standby, 1'b1);
            results();
        end
    endtask

    // Random frame; a stalled consumer overruns the two-entry buffer
    task automatic frame(input int n, input int ntx, input logic rdy);
        logic [7:0] si_b [8];
        logic [7:0] so_b [8];
        logic [7:0] txv [8];
        rxq.delete();
        n_ovr = 0;
        rx_ready = rdy;
        for (int k = 0; k < n; k++) begin
            si_b[k] = rnd();
            txv[k] = rnd();
            if (k < ntx)
                txq.push_back(txv[k]);
        end
        tx_show();
        host_u.sel();
        for (int k = 0; k < n; k++)
            host_u.xbyte(si_b[k], 8, so_b[k]);
        host_u.desel();
        rx_ready = 1'b1;
        tick(4);
        chkn(rxq.size(), rdy ? n : 2);
        chkn(n_ovr, rdy ? 0 : n - 2);
        chk1(rx_valid, 1'b0);
        chk1(so_oe, 1'b0);
        chk1(standby, 1'b1);
        for (int k = 0; k < n && k < rxq.size(); k++)
            chk9(rxq[k], {k == 0, si_b[k]});
        for (int k = 0; k < n; k++)
            chk9({1'b0, so_b[k]}, exp_so(k, ntx, txv[k]));
        $display("test frame done");
    endtask

    task automatic pe_pulse();
        pe_cmd = 1'b1;
        tick(1);
        pe_cmd = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        wp_n = 1'b1;
        reset_n = 1'b1;
        rx_ready = 1'b1;
        pe_cmd = 1'b0;
        pe_done = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        tick(5);
        srst = 1'b0;
        tick(2);
        chk1(in_reset, 1'b1);
        chk1(so_oe, 1'b0);
        wait_sb();
        chk1(in_reset, 1'b0);
        $display("test power_on done");
        rxq.delete();
        host_u.noise();
        chkn(rxq.size(), 0);
        chk1(so_oe, 1'b0);
        $display("test deselected_noise done");
        for (int t = 0; t < 6; t++)
            frame(1 + t % 4, t % 3, 1'b1);
        frame(4, 4, 1'b0);
        // A byte cut short by select rise is thrown away
        rxq.delete();
        host_u.sel();
        host_u.xbyte(8'hA5, 8, r);
        host_u.xbyte(8'h3C, 4, r);
        host_u.desel();
        tick(4);
        chkn(rxq.size(), 1);
        chk9(rxq[0], 9'h1A5);
        $display("test partial done");
        // Program with protect high runs past select rise
        n_start = 0;
        host_u.sel();
        pe_pulse();
        host_u.xbyte(rnd(), 8, r);
        host_u.desel();
        chkn(n_start, 1);
        chk1(busy, 1'b1);
        chk1(standby, 1'b0);
        rxq.delete();
        host_u.sel();
        chk1(so_oe, 1'b0);
        host_u.xbyte(rnd(), 8, r);
        host_u.desel();
        chkn(rxq.size(), 0);
        pe_done = 1'b1;
        tick(1);
        pe_done = 1'b0;
        wait_sb();
        chk1(busy, 1'b0);
        $display("test busy done");
        // Protect falling after arming still stops the start
        n_start = 0;
        host_u.sel();
        pe_pulse();
        host_u.xbyte(rnd(), 8, r);
        wp_n = 1'b0;
        tick(8);
        host_u.desel();
        chkn(n_start, 0);
        chk1(standby, 1'b1);
        // Protect low drops the command and locks protection changes
        chk1(spr_write_ok, 1'b0);
        n_rej = 0;
        host_u.sel();
        pe_pulse();
        host_u.xbyte(rnd(), 8, r);
        host_u.desel();
        chkn(n_rej, 1);
        chkn(n_start, 0);
        chk1(busy, 1'b0);
        chk1(standby, 1'b1);
        wp_n = 1'b1;
        tick(8);
        chk1(spr_write_ok, 1'b1);
        $display("test protect done");
        // Reset pin low in mid-frame aborts and holds
        n_abort = 0;
        host_u.sel();
        host_u.xbyte(rnd(), 4, r);
        reset_n = 1'b0;
        tick(8);
        chkn(n_abort, 1);
        chk1(in_reset, 1'b1);
        chk1(so_oe, 1'b0);
        tick(40);
        chk1(in_reset, 1'b1);
        chk1(standby, 1'b0);
        host_u.desel();
        reset_n = 1'b1;
        wait_sb();
        chk1(in_reset, 1'b0);
        $display("test reset_pin done");
        frame(2, 2, 1'b1);
        results();
    end
endmodule
